// *** include/ftb_pkg.sv ***
package ftb_pkg;
    // Register byte addresses on the core register port.
    localparam logic [7:0] ADDR_T0_CTRL  = 8'h05;
    localparam logic [7:0] ADDR_T0_LOW   = 8'h0B;
    localparam logic [7:0] ADDR_T0_HIGH  = 8'h0C;
    localparam logic [7:0] ADDR_MODE     = 8'h10;
    localparam logic [7:0] ADDR_CNT1     = 8'h11;
    localparam logic [7:0] ADDR_CNT2     = 8'h12;
    localparam logic [7:0] ADDR_PER1     = 8'h13;
    localparam logic [7:0] ADDR_PER2     = 8'h14;
    localparam logic [7:0] ADDR_CNT3_LOW = 8'h15;
    localparam logic [7:0] ADDR_CNT3_HI  = 8'h16;
    localparam logic [7:0] ADDR_PER3_LOW = 8'h17;
    localparam logic [7:0] ADDR_PER3_HI  = 8'h18;
    localparam logic [7:0] ADDR_FLAGS    = 8'h19;
    localparam logic [7:0] ADDR_ENABLE   = 8'h1A;

    // Field positions of timer0_control.
    localparam int CTRL_IRQ_EDGE = 7;
    localparam int CTRL_EDGE_SEL = 6;
    localparam int CTRL_SRC_SEL  = 5;
    localparam int CTRL_PS_TOP   = 4;
    localparam int CTRL_PS_LOW   = 1;

    // Field positions of timer_mode.
    localparam int MODE_T1_EXT = 0;
    localparam int MODE_T2_EXT = 1;
    localparam int MODE_T16    = 2;
    localparam int MODE_T3_EXT = 3;
    localparam int MODE_T3_CAP = 4;
    localparam int MODE_T1_ON  = 5;
    localparam int MODE_T2_ON  = 6;
    localparam int MODE_T3_ON  = 7;

    // Event flag and enable positions.
    localparam int FLAG_T0_OVF  = 0;
    localparam int FLAG_EXT_CLK = 1;
    localparam int FLAG_EXT_IRQ = 2;
    localparam int FLAG_T1_WRAP = 3;
    localparam int FLAG_T2_WRAP = 4;
    localparam int FLAG_T3_WRAP = 5;
    localparam int NUM_FLAGS    = 6;

    // Pin positions inside the synchroniser vectors.
    localparam int PIN_T0  = 0;
    localparam int PIN_IRQ = 1;
    localparam int PIN_SH  = 2;
    localparam int PIN_T3  = 3;
    localparam int PIN_CAP = 4;
    localparam int NUM_PINS = 5;

    // Reset values and constants.
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [7:0]  BYTE_ONES = 8'hFF;
    localparam logic [15:0] WORD_ONES = 16'hFFFF;

    // Complete state of the time-base block.
    typedef struct packed {
        logic [NUM_PINS-1:0]  s1;
        logic [NUM_PINS-1:0]  s2;
        logic [NUM_PINS-1:0]  s3;
        logic [7:0]           ctrl;
        logic [7:0]           pre0;
        logic [15:0]          cnt0;
        logic                 inh_lo;
        logic                 inh_hi;
        logic [7:0]           mode;
        logic [7:0]           cnt1;
        logic [7:0]           cnt2;
        logic [7:0]           per1;
        logic [7:0]           per2;
        logic [15:0]          cnt3;
        logic [15:0]          per3;
        logic [NUM_FLAGS-1:0] flags;
        logic [NUM_FLAGS-1:0] en;
        logic [7:0]           rdata;
    } ftb_state_t;
endpackage

// *** rtl/ftb_top.sv ***
// Behaviour
// - Timer0 count is 16 bits, high and low bytes each software accessible.
// - An 8-bit prescaler ahead of Timer0 gives 24 effective count bits.
// - Source select 1 picks instruction clock, 0 picks the external pin.
// - Internal Timer0 source is the instruction clock, oscillator over four.
// - Edge select 1 counts rising, 0 falling; counted edges set edge flag.
// - Prescale select in control bits 4 to 1 chooses 1:1 through 1:256.
// - External input is synchronised to the internal clock, then prescaled.
// - Control bit 7 picks external interrupt pin edge: 1 rising, 0 falling.
// - Each timer raises an interrupt request only when its enable is set.
// - Timer1 counts to its period value, then wraps to zero setting its flag.
// - Timer2 counts to its period value, then wraps to zero setting its flag.
// - In counter mode Timers 1 and 2 count the shared external clock pin.
// - Chained mode: Timer1 low, Timer2 high, 16-bit period, only Timer1 flag.
// - Timer3 is 16 bits with a 16-bit period; wrapping sets its flag.
// - In counter mode Timer3 counts its own external clock pin.
// - In capture mode Timer3 period pair becomes the second capture register.
// - Timer0 counts 0000h to FFFFh, wraps, and sets its overflow flag.
// - A write to a Timer0 byte clears the prescaler and holds that half.
// - The prescaler carry increments Timer0 in the same cycle, without edge sampling.
module ftb_top (
    input  wire logic        sys_clk_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [7:0]       reg_rdata_out,
    input  wire logic        counter_zero_ext_clk_pin_in,
    input  wire logic        ext_irq_pin_in,
    input  wire logic        shared_count_clk_pin_in,
    input  wire logic        third_count_clk_pin_in,
    input  wire logic        capture_two_pin_in,
    output logic [ftb_pkg::NUM_FLAGS-1:0] irq_req_out
);
    import ftb_pkg::*;

    ftb_state_t           st;
    ftb_state_t           nx;
    logic [NUM_PINS-1:0]  rise;
    logic [NUM_PINS-1:0]  fall;
    logic [NUM_FLAGS-1:0] fset;
    logic [NUM_FLAGS-1:0] fclr;
    logic [3:0]           ps;
    logic [7:0]           mask0;
    logic                 ev0;
    logic                 tick0;
    logic                 inc_lo;
    logic                 inc_hi;
    logic                 ev1;
    logic                 ev2;
    logic                 ev3;
    logic                 wr;

    // Edge detection looks only at the second and third synchroniser stages.
    assign rise = st.s2 & ~st.s3;
    assign fall = ~st.s2 & st.s3;
    assign wr   = reg_wr_in;
    assign ps   = st.ctrl[CTRL_PS_TOP:CTRL_PS_LOW];

    assign irq_req_out   = st.flags & st.en;
    assign reg_rdata_out = st.rdata;

    // Next-state logic for the whole block.
    always_comb begin
        nx    = st;
        fset  = '0;
        fclr  = '0;
        // Pins pass two flip-flops; the third stage only remembers the last level.
        nx.s1 = {capture_two_pin_in, third_count_clk_pin_in, shared_count_clk_pin_in,
                 ext_irq_pin_in, counter_zero_ext_clk_pin_in};
        nx.s2 = st.s1;
        nx.s3 = st.s2;
        nx.inh_lo = 1'b0;
        nx.inh_hi = 1'b0;
        nx.rdata  = RST_BYTE;

        if (st.ctrl[CTRL_SRC_SEL]) begin
            ev0 = 1'b1;
        end else begin
            ev0 = st.ctrl[CTRL_EDGE_SEL] ? rise[PIN_T0] : fall[PIN_T0];
        end
        if (!st.ctrl[CTRL_SRC_SEL] && ev0) begin
            fset[FLAG_EXT_CLK] = 1'b1;
        end

        mask0 = ps[3] ? BYTE_ONES : ~(BYTE_ONES << ps[2:0]);
        tick0 = ev0 && ((st.pre0 & mask0) == mask0);
        if (ev0) begin
            nx.pre0 = st.pre0 + 8'h01;
        end

        // Timer0 carry chain, each half held in the cycle after its write.
        inc_lo = tick0 && !st.inh_lo;
        inc_hi = inc_lo && (st.cnt0[7:0] == BYTE_ONES) && !st.inh_hi;
        if (inc_lo) begin
            nx.cnt0[7:0] = st.cnt0[7:0] + 8'h01;
        end
        if (inc_hi) begin
            nx.cnt0[15:8] = st.cnt0[15:8] + 8'h01;
            if (st.cnt0[15:8] == BYTE_ONES) begin
                fset[FLAG_T0_OVF] = 1'b1;
            end
        end

        if (st.ctrl[CTRL_IRQ_EDGE] ? rise[PIN_IRQ] : fall[PIN_IRQ]) begin
            fset[FLAG_EXT_IRQ] = 1'b1;
        end

        ev1 = st.mode[MODE_T1_ON] && (st.mode[MODE_T1_EXT] ? fall[PIN_SH] : 1'b1);
        ev2 = st.mode[MODE_T2_ON] && (st.mode[MODE_T2_EXT] ? fall[PIN_SH] : 1'b1);
        if (st.mode[MODE_T16]) begin
            if (ev1) begin
                if ({st.cnt2, st.cnt1} == {st.per2, st.per1}) begin
                    nx.cnt1 = RST_BYTE;
                    nx.cnt2 = RST_BYTE;
                    fset[FLAG_T1_WRAP] = 1'b1;
                end else begin
                    {nx.cnt2, nx.cnt1} = {st.cnt2, st.cnt1} + 16'h0001;
                end
            end
        end else begin
            if (ev1) begin
                if (st.cnt1 == st.per1) begin
                    nx.cnt1 = RST_BYTE;
                    fset[FLAG_T1_WRAP] = 1'b1;
                end else begin
                    nx.cnt1 = st.cnt1 + 8'h01;
                end
            end
            if (ev2) begin
                if (st.cnt2 == st.per2) begin
                    nx.cnt2 = RST_BYTE;
                    fset[FLAG_T2_WRAP] = 1'b1;
                end else begin
                    nx.cnt2 = st.cnt2 + 8'h01;
                end
            end
        end

        ev3 = st.mode[MODE_T3_ON] && (st.mode[MODE_T3_EXT] ? fall[PIN_T3] : 1'b1);
        if (ev3) begin
            if ((!st.mode[MODE_T3_CAP] && st.cnt3 == st.per3) || st.cnt3 == WORD_ONES) begin
                nx.cnt3 = RST_WORD;
                fset[FLAG_T3_WRAP] = 1'b1;
            end else begin
                nx.cnt3 = st.cnt3 + 16'h0001;
            end
        end
        if (st.mode[MODE_T3_CAP] && rise[PIN_CAP]) begin
            nx.per3 = st.cnt3;
        end

        // Software writes take precedence over counting in the same cycle.
        if (wr) begin
            unique case (reg_addr_in)
                ADDR_T0_CTRL:  nx.ctrl = {reg_wdata_in[7:1], 1'b0};
                ADDR_T0_LOW: begin
                    nx.cnt0[7:0] = reg_wdata_in;
                    nx.pre0      = RST_BYTE;
                    nx.inh_lo    = 1'b1;
                end
                ADDR_T0_HIGH: begin
                    nx.cnt0[15:8] = reg_wdata_in;
                    nx.pre0       = RST_BYTE;
                    nx.inh_hi     = 1'b1;
                end
                ADDR_MODE:     nx.mode = reg_wdata_in;
                ADDR_CNT1:     nx.cnt1 = reg_wdata_in;
                ADDR_CNT2:     nx.cnt2 = reg_wdata_in;
                ADDR_PER1:     nx.per1 = reg_wdata_in;
                ADDR_PER2:     nx.per2 = reg_wdata_in;
                ADDR_CNT3_LOW: nx.cnt3[7:0] = reg_wdata_in;
                ADDR_CNT3_HI:  nx.cnt3[15:8] = reg_wdata_in;
                ADDR_PER3_LOW: nx.per3[7:0] = reg_wdata_in;
                ADDR_PER3_HI:  nx.per3[15:8] = reg_wdata_in;
                ADDR_FLAGS:    fclr = reg_wdata_in[NUM_FLAGS-1:0];
                ADDR_ENABLE:   nx.en = reg_wdata_in[NUM_FLAGS-1:0];
                default: ;
            endcase
        end
        // Write-one-to-clear; a flag set in the same cycle survives the clear.
        nx.flags = (st.flags & ~fclr) | fset;

        // Read data stand in the cycle after the strobe only.
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_T0_CTRL:  nx.rdata = st.ctrl;
                ADDR_T0_LOW:   nx.rdata = st.cnt0[7:0];
                ADDR_T0_HIGH:  nx.rdata = st.cnt0[15:8];
                ADDR_MODE:     nx.rdata = st.mode;
                ADDR_CNT1:     nx.rdata = st.cnt1;
                ADDR_CNT2:     nx.rdata = st.cnt2;
                ADDR_PER1:     nx.rdata = st.per1;
                ADDR_PER2:     nx.rdata = st.per2;
                ADDR_CNT3_LOW: nx.rdata = st.cnt3[7:0];
                ADDR_CNT3_HI:  nx.rdata = st.cnt3[15:8];
                ADDR_PER3_LOW: nx.rdata = st.per3[7:0];
                ADDR_PER3_HI:  nx.rdata = st.per3[15:8];
                ADDR_FLAGS:    nx.rdata = {2'b00, st.flags};
                ADDR_ENABLE:   nx.rdata = {2'b00, st.en};
                default:       nx.rdata = RST_BYTE;
            endcase
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    sequence seq_wr_low;
        reg_wr_in && reg_addr_in == ADDR_T0_LOW;
    endsequence

    sequence seq_wr_high;
        reg_wr_in && reg_addr_in == ADDR_T0_HIGH;
    endsequence

    sequence seq_quiet;
        !reg_wr_in;
    endsequence

    sequence seq_t0_top;
        st.cnt0 == WORD_ONES && inc_lo && !st.inh_hi;
    endsequence

    AST_CTRL_BIT0: assert property (reg_rd_in && reg_addr_in == ADDR_T0_CTRL |=> !reg_rdata_out[0])
        else $error("control bit 0 read back as one");

    AST_T0_WRAP: assert property (seq_t0_top ##0 seq_quiet |=> st.cnt0 == RST_WORD && st.flags[FLAG_T0_OVF])
        else $error("timer0 did not wrap with overflow flag");

    AST_WR_CLR_PRE: assert property (seq_wr_low |=> st.pre0 == RST_BYTE && st.cnt0[7:0] == $past(reg_wdata_in))
        else $error("low byte write did not load or clear prescaler");

    AST_WR_HOLD: assert property (seq_wr_low ##1 seq_quiet |=> st.cnt0[7:0] == $past(st.cnt0[7:0]))
        else $error("low byte advanced in the cycle after its write");

    AST_INT_SRC: assert property (st.ctrl[CTRL_SRC_SEL] && ps == 4'h0 && !st.inh_lo && !reg_wr_in
        |=> st.cnt0[7:0] == $past(st.cnt0[7:0]) + 8'h01)
        else $error("timer0 did not advance every cycle on internal source");

    AST_PS_256: assert property (st.ctrl[CTRL_SRC_SEL] && ps[3] && st.pre0 != BYTE_ONES && !reg_wr_in
        |=> st.cnt0 == $past(st.cnt0))
        else $error("prescale 1:256 ticked early");

    AST_EXT_EDGE: assert property (!st.ctrl[CTRL_SRC_SEL] && st.ctrl[CTRL_EDGE_SEL] && rise[PIN_T0]
        |=> st.flags[FLAG_EXT_CLK])
        else $error("rising external edge did not set edge flag");

    AST_T1_WRAP: assert property (!st.mode[MODE_T16] && ev1 && st.cnt1 == st.per1 && !reg_wr_in
        |=> st.cnt1 == RST_BYTE && st.flags[FLAG_T1_WRAP])
        else $error("timer1 did not wrap at period match");

    AST_T16_WRAP: assert property (st.mode[MODE_T16] && ev1 && {st.cnt2, st.cnt1} == {st.per2, st.per1}
        && !reg_wr_in && !st.flags[FLAG_T2_WRAP]
        |=> st.cnt2 == RST_BYTE && st.flags[FLAG_T1_WRAP] && !st.flags[FLAG_T2_WRAP])
        else $error("chained timer wrap wrong");

    AST_T3_WRAP: assert property (!st.mode[MODE_T3_CAP] && ev3 && st.cnt3 == st.per3 && !reg_wr_in
        |=> st.cnt3 == RST_WORD && st.flags[FLAG_T3_WRAP])
        else $error("timer3 did not wrap at period match");

    AST_WR_HOLD_HI: assert property (seq_wr_high ##1 seq_quiet |=> st.cnt0[15:8] == $past(st.cnt0[15:8]))
        else $error("high byte advanced in the cycle after its write");

    AST_EXT_FALL: assert property (!st.ctrl[CTRL_SRC_SEL] && !st.ctrl[CTRL_EDGE_SEL] && fall[PIN_T0]
        |=> st.flags[FLAG_EXT_CLK])
        else $error("falling external edge did not set edge flag");

    AST_INT_NO_FLAG: assert property (st.ctrl[CTRL_SRC_SEL] && !st.flags[FLAG_EXT_CLK]
        |=> !st.flags[FLAG_EXT_CLK])
        else $error("edge flag set while internal source selected");

    AST_IRQ_RISE: assert property (st.ctrl[CTRL_IRQ_EDGE] && rise[PIN_IRQ] |=> st.flags[FLAG_EXT_IRQ])
        else $error("rising interrupt pin edge missed");

    AST_IRQ_FALL: assert property (!st.ctrl[CTRL_IRQ_EDGE] && fall[PIN_IRQ] |=> st.flags[FLAG_EXT_IRQ])
        else $error("falling interrupt pin edge missed");

    AST_T2_WRAP: assert property (!st.mode[MODE_T16] && ev2 && st.cnt2 == st.per2 && !reg_wr_in
        |=> st.cnt2 == RST_BYTE && st.flags[FLAG_T2_WRAP])
        else $error("timer2 did not wrap at period match");

    AST_SH_HOLD: assert property (st.mode[MODE_T1_ON] && st.mode[MODE_T1_EXT] && !fall[PIN_SH]
        && !reg_wr_in |=> st.cnt1 == $past(st.cnt1))
        else $error("timer1 moved without a shared pin edge");

    AST_SH_STEP: assert property (st.mode[MODE_T2_ON] && st.mode[MODE_T2_EXT] && !st.mode[MODE_T16]
        && fall[PIN_SH] && st.cnt2 != st.per2 && !reg_wr_in |=> st.cnt2 == $past(st.cnt2) + 8'h01)
        else $error("timer2 did not step on a shared pin edge");

    AST_T16_CARRY: assert property (st.mode[MODE_T16] && ev1 && st.cnt1 == BYTE_ONES && !reg_wr_in
        && {st.cnt2, st.cnt1} != {st.per2, st.per1}
        |=> st.cnt1 == RST_BYTE && st.cnt2 == $past(st.cnt2) + 8'h01)
        else $error("chained carry into timer2 missing");

    AST_T3_HOLD: assert property (st.mode[MODE_T3_ON] && st.mode[MODE_T3_EXT] && !fall[PIN_T3]
        && !reg_wr_in |=> st.cnt3 == $past(st.cnt3))
        else $error("timer3 moved without its pin edge");

    AST_CAPTURE: assert property (st.mode[MODE_T3_CAP] && rise[PIN_CAP] && !reg_wr_in
        |=> st.per3 == $past(st.cnt3))
        else $error("capture pin edge did not load the period pair");

    AST_CAP_NO_MATCH: assert property (st.mode[MODE_T3_CAP] && ev3 && st.cnt3 != WORD_ONES && !reg_wr_in
        |=> st.cnt3 == $past(st.cnt3) + 16'h0001)
        else $error("timer3 matched its period in capture mode");
endmodule

// *** tb/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ftb_pkg::*;

    logic                 sys_clk_in   = 1'b0;
    logic                 srst_in      = 1'b1;
    logic [7:0]           reg_addr     = 8'h00;
    logic [7:0]           reg_wdata    = 8'h00;
    logic                 reg_wr       = 1'b0;
    logic                 reg_rd       = 1'b0;
    logic [7:0]           reg_rdata;
    logic [NUM_PINS-1:0]  pins         = '0;
    logic [NUM_FLAGS-1:0] irq_req;
    logic [7:0]           a;
    logic [7:0]           b;
    logic [7:0]           map_list [15];
    int                   errors       = 0;
    int                   total_checks = 0;
    int                   dv;

    ftb_top DUT (
        .sys_clk_in                  (sys_clk_in),
        .srst_in                     (srst_in),
        .reg_addr_in                 (reg_addr),
        .reg_wdata_in                (reg_wdata),
        .reg_wr_in                   (reg_wr),
        .reg_rd_in                   (reg_rd),
        .reg_rdata_out               (reg_rdata),
        .counter_zero_ext_clk_pin_in (pins[PIN_T0]),
        .ext_irq_pin_in              (pins[PIN_IRQ]),
        .shared_count_clk_pin_in     (pins[PIN_SH]),
        .third_count_clk_pin_in      (pins[PIN_T3]),
        .capture_two_pin_in          (pins[PIN_CAP]),
        .irq_req_out                 (irq_req)
    );

    // The clock toggles every half period of 20 ns.
    always #20 sys_clk_in = ~sys_clk_in;

    // Compares one byte and counts the result.
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr  <= ad;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr    <= 1'b0;
    endtask

    // One-cycle read strobe; data is taken in the following cycle.
    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd   <= 1'b0;
        @(negedge sys_clk_in);
        d = reg_rdata;
    endtask

    // Moves one pin and lets the synchroniser settle.
    task automatic set_pin(input int idx, input logic v);
        @(posedge sys_clk_in);
        pins[idx] <= v;
        repeat (6) @(posedge sys_clk_in);
    endtask

    // Reads a register and compares it.
    task automatic rd_chk(input logic [7:0] ad, input logic [7:0] mask, input logic [7:0] exp);
        rd(ad, a);
        check8(a & mask, exp);
    endtask

    // Two reads two cycles apart must step by two modulo period plus one.
    task automatic wrap_chk(input logic [7:0] ad, input logic [7:0] per);
        rd(ad, a);
        rd(ad, b);
        check8(b, (a + 8'h02) % (per + 8'h01));
    endtask

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (100000) @(posedge sys_clk_in);
        errors++;
        summarize();
    end

    // Main sequence of register calls and expectations.
    initial begin
        map_list = '{8'h05, 8'h0B, 8'h0C, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
                     8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h00};
        repeat (4) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        foreach (map_list[i]) rd_chk(map_list[i], 8'hFF, 8'h00);
        check8({2'b00, irq_req}, 8'h00);
        wr(8'h00, 8'hA5);
        rd_chk(8'h00, 8'hFF, 8'h00);
        wr(ADDR_T0_CTRL, 8'hFF);
        rd_chk(ADDR_T0_CTRL, 8'hFF, 8'hFE);
        for (int i = 0; i < 10; i++) begin
            dv = (i < 8) ? (1 << i) : 256;
            wr(ADDR_T0_CTRL, {3'b001, (i < 9) ? 4'(i) : 4'hF, 1'b0});
            rd(ADDR_T0_LOW, a);
            repeat (4 * dv - 2) @(posedge sys_clk_in);
            rd(ADDR_T0_LOW, b);
            check8(b - a, 8'h04);
        end
        wr(ADDR_T0_CTRL, 8'h00);
        wr(ADDR_T0_LOW, 8'hFF);
        wr(ADDR_T0_HIGH, 8'hFF);
        wr(ADDR_FLAGS, 8'h3F);
        set_pin(PIN_T0, 1'b1);
        rd_chk(ADDR_T0_LOW, 8'hFF, 8'hFF);
        set_pin(PIN_T0, 1'b0);
        rd_chk(ADDR_T0_LOW, 8'hFF, 8'h00);
        rd_chk(ADDR_T0_HIGH, 8'hFF, 8'h00);
        rd_chk(ADDR_FLAGS, 8'h03, 8'h03);
        check8({2'b00, irq_req}, 8'h00);
        wr(ADDR_ENABLE, 8'h01);
        @(negedge sys_clk_in);
        check8({2'b00, irq_req}, 8'h01);
        wr(ADDR_FLAGS, 8'h01);
        @(negedge sys_clk_in);
        check8({2'b00, irq_req}, 8'h00);
        wr(ADDR_T0_CTRL, 8'h40);
        set_pin(PIN_T0, 1'b1);
        rd_chk(ADDR_T0_LOW, 8'hFF, 8'h01);
        set_pin(PIN_T0, 1'b0);
        rd_chk(ADDR_T0_LOW, 8'hFF, 8'h01);
        wr(ADDR_T0_CTRL, 8'h44);
        wr(ADDR_T0_LOW, 8'h00);
        repeat (3) begin
            set_pin(PIN_T0, 1'b1);
            set_pin(PIN_T0, 1'b0);
        end
        wr(ADDR_T0_LOW, 8'h00);
        repeat (3) begin
            set_pin(PIN_T0, 1'b1);
            set_pin(PIN_T0, 1'b0);
        end
        rd_chk(ADDR_T0_LOW, 8'hFF, 8'h00);
        set_pin(PIN_T0, 1'b1);
        rd_chk(ADDR_T0_LOW, 8'hFF, 8'h01);
        wr(ADDR_T0_CTRL, 8'h80);
        wr(ADDR_FLAGS, 8'h3F);
        set_pin(PIN_IRQ, 1'b1);
        rd_chk(ADDR_FLAGS, 8'h04, 8'h04);
        wr(ADDR_T0_CTRL, 8'h00);
        wr(ADDR_FLAGS, 8'h04);
        set_pin(PIN_IRQ, 1'b0);
        rd_chk(ADDR_FLAGS, 8'h04, 8'h04);
        wr(ADDR_FLAGS, 8'h04);
        set_pin(PIN_IRQ, 1'b1);
        rd_chk(ADDR_FLAGS, 8'h04, 8'h00);
        wr(ADDR_PER1, 8'h03);
        wr(ADDR_PER2, 8'h05);
        wr(ADDR_MODE, 8'h60);
        wrap_chk(ADDR_CNT1, 8'h03);
        wrap_chk(ADDR_CNT2, 8'h05);
        rd_chk(ADDR_FLAGS, 8'h18, 8'h18);
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_PER1, 8'hFF);
        wr(ADDR_PER2, 8'hFF);
        wr(ADDR_CNT1, 8'h00);
        wr(ADDR_CNT2, 8'h00);
        wr(ADDR_MODE, 8'h63);
        repeat (3) begin
            set_pin(PIN_SH, 1'b1);
            set_pin(PIN_SH, 1'b0);
        end
        rd_chk(ADDR_CNT1, 8'hFF, 8'h03);
        rd_chk(ADDR_CNT2, 8'hFF, 8'h03);
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_PER1, 8'h80);
        wr(ADDR_PER2, 8'h01);
        wr(ADDR_CNT1, 8'h00);
        wr(ADDR_CNT2, 8'h00);
        wr(ADDR_FLAGS, 8'h3F);
        wr(ADDR_MODE, 8'h64);
        repeat (300) @(posedge sys_clk_in);
        rd_chk(ADDR_CNT2, 8'hFF, 8'h01);
        repeat (200) @(posedge sys_clk_in);
        rd_chk(ADDR_FLAGS, 8'h18, 8'h08);
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_CNT3_LOW, 8'hFE);
        wr(ADDR_CNT3_HI, 8'hFF);
        wr(ADDR_PER3_LOW, 8'hFF);
        wr(ADDR_PER3_HI, 8'hFF);
        wr(ADDR_FLAGS, 8'h3F);
        wr(ADDR_MODE, 8'h88);
        repeat (2) begin
            set_pin(PIN_T3, 1'b1);
            set_pin(PIN_T3, 1'b0);
        end
        rd_chk(ADDR_CNT3_LOW, 8'hFF, 8'h00);
        rd_chk(ADDR_CNT3_HI, 8'hFF, 8'h00);
        rd_chk(ADDR_FLAGS, 8'h20, 8'h20);
        wr(ADDR_PER3_LOW, 8'h05);
        wr(ADDR_PER3_HI, 8'h00);
        wr(ADDR_MODE, 8'h90);
        repeat (20) @(posedge sys_clk_in);
        rd(ADDR_CNT3_LOW, a);
        check8(8'(a > 8'h05), 8'h01);
        set_pin(PIN_CAP, 1'b1);
        rd(ADDR_PER3_LOW, a);
        rd(ADDR_PER3_LOW, b);
        check8(b, a);
        check8(8'(a != 8'h05), 8'h01);
        summarize();
    end
endmodule
